// file: bench/sram_host_ctrl_tb.sv
`timescale 1ns/1ps
module sram_host_ctrl_tb;
   import sram_ctrl_pkg::*;
   typedef struct packed { logic wr; logic [DATA_W-1:0] data; } note_s;
   logic              sys_clk = 1'b0;
   logic              rst_b;
   logic              req_valid;
   mem_req_s          req;
   logic              req_ready;
   logic              rd_valid;
   logic              wr_done;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] bus_o;
   logic [DATA_W-1:0] bus_oe;
   logic [DATA_W-1:0] bus;
   logic [DATA_W-1:0] dev_d;
   logic [DATA_W-1:0] dev_oe;
   pin_ctl_s          pins;
   note_s             notes[$];
   logic [DATA_W-1:0] ref_mem [int];
   int                errors = 0;
   int                comparisons = 0;
   int                cycles = 0;
   int                seed = 40438;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] d1;
   logic [DATA_W-1:0] d2;
   always #2 sys_clk = ~sys_clk;
   // an undriven line toggles every cycle so a stale value never looks valid
   assign bus = (bus_oe & bus_o) | (~bus_oe & dev_oe & dev_d) | (~bus_oe & ~dev_oe & ({16{cycles[0]}} ^ 16'h5a3c));
   sram_host_ctrl u_sram_host_ctrl (
      .sys_clk_i(sys_clk), .rst_b_i(rst_b), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
      .rd_valid_o(rd_valid), .rd_data_o(rd_data), .wr_done_o(wr_done), .pins_o(pins),
      .shared_data_bus_i(bus), .shared_data_bus_o(bus_o), .shared_data_bus_oe_o(bus_oe));
   sram_model u_sram_model (.pins_i(pins), .bus_i(bus), .dev_d_o(dev_d), .dev_oe_o(dev_oe));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input logic [16:0] seen, input logic [16:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task final_report;
      $display("comparisons=%0d errors=%0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one request; the expected result is noted before the request is taken
   task do_req(input logic wr, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d, input logic [1:0] ln);
      logic [DATA_W-1:0] old;
      begin
         @(negedge sys_clk);
         for (int k = 0; k < 20 && req_ready !== 1'b1; k++) @(negedge sys_clk);
         old = ref_mem.exists(ad) ? ref_mem[ad] : 16'h0;
         if (wr) begin
            ref_mem[ad] = {ln[1] ? old[15:8] : d[15:8], ln[0] ? old[7:0] : d[7:0]};
            notes.push_back({1'b1, 16'h0});
         end else begin
            notes.push_back({1'b0, ln[1] ? 8'h0 : old[15:8], ln[0] ? 8'h0 : old[7:0]});
         end
         req_valid = 1'b1;
         req = '{write: wr, addr: ad, wdata: d, lane_n: ln};
         @(negedge sys_clk);
         req_valid = 1'b0;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin : monitor
      note_s n;
      if (rst_b === 1'b1 && (rd_valid === 1'b1 || wr_done === 1'b1)) begin
         if (notes.size() == 0) n = 17'h1ffff;
         else n = notes.pop_front();
         check({wr_done, wr_done ? 16'h0 : rd_data}, n);
      end
      if (rst_b === 1'b1) check({1'b0, bus_oe & dev_oe}, 17'h0);
   end
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         errors++;
         final_report();
      end
   end
   initial begin
      rst_b = 1'b0;
      req_valid = 1'b0;
      req = '0;
      repeat (4) @(negedge sys_clk);
      check({pins.chip_sel_n, pins.write_n, pins.out_en_n, req_ready, 13'h0}, {4'hf, 13'h0});
      rst_b = 1'b1;
      for (int i = 0; i < 30; i++) begin
         a = (i == 0) ? 18'h0 : (i == 1) ? 18'h3ffff : 18'($random(seed));
         d1 = 16'($random(seed));
         d2 = 16'($random(seed));
         do_req(1'b1, a, d1, 2'b00);
         do_req(1'b1, a, d2, 2'(i % 4));
         do_req(1'b0, a, 16'h0, 2'($random(seed)));
         do_req(1'b0, a, 16'h0, 2'b00);
      end
      for (int k = 0; k < 50 && notes.size() > 0; k++) @(negedge sys_clk);
      check(17'(notes.size()), 17'h0);
      final_report();
   end
endmodule // sram_host_ctrl_tb

// file: bench/sram_model.sv
`timescale 1ns/1ps
module sram_model
   import sram_ctrl_pkg::*;
(
   input  wire sram_ctrl_pkg::pin_ctl_s pins_i,
   input  wire logic [DATA_W-1:0]       bus_i,
   output logic [DATA_W-1:0]            dev_d_o,
   output logic [DATA_W-1:0]            dev_oe_o
);
   import sram_ctrl_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic              wr_act;
   logic              rd_act;
   logic              acc_ok;
   logic [ADDR_W-1:0] a;
   realtime           last_chg;
   assign a      = pins_i.word_address;
   assign wr_act = !pins_i.chip_sel_n && !pins_i.write_n;
   // simultaneous release of select and strobe never opens a read window
   assign rd_act = !pins_i.chip_sel_n && !pins_i.out_en_n && pins_i.write_n;
   // data is wrong until the access time has run, so early sampling is caught
   // a stale timer from an earlier change must not mark the new access valid early
   always @(pins_i.word_address or pins_i.chip_sel_n) begin
      last_chg = $realtime;
      acc_ok = 1'b0;
      fork
         begin
            #11.5;
            if ($realtime - last_chg >= 11.5) acc_ok = 1'b1;
         end
      join_none
   end
   assign dev_d_o  = acc_ok ? mem[a] : ~mem[a];
   assign dev_oe_o = {{8{rd_act && !pins_i.upper_lane_enable_n}}, {8{rd_act && !pins_i.lower_lane_enable_n}}};
   // the word is taken at the end of the overlap of select and strobe
   always @(negedge wr_act) begin
      if (!pins_i.lower_lane_enable_n) mem[a][7:0] = bus_i[7:0];
      if (!pins_i.upper_lane_enable_n) mem[a][15:8] = bus_i[15:8];
   end
endmodule // sram_model

// file: design/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer
   import sram_ctrl_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         sys_clk_i,
   input  wire logic         rst_b_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output logic              done_o
);
   typedef struct packed {
      logic [W-1:0] cnt;
   } tmr_s;

   tmr_s st_r;
   tmr_s st_nxt;

   always_comb begin
      st_nxt = st_r;
      if (load_i) begin
         st_nxt.cnt = count_i;
      end else if (st_r.cnt != '0) begin
         st_nxt.cnt = st_r.cnt - W'(1);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // done is combinational on the count so the sequencer can move the same cycle
   assign done_o = (st_r.cnt == W'(1));
endmodule // cycle_timer

// file: design/sram_ctrl_pkg.sv
package sram_ctrl_pkg;

   localparam int ADDR_W = 18;
   localparam int DATA_W = 16;
   localparam int LANES  = 2;

   // timing figures in ns, clock period in ns
   localparam int CLK_PERIOD_NS = 4;
   localparam int T_RC_NS       = 12;
   localparam int T_AA_NS       = 12;
   localparam int T_PWE_NS      = 10;
   localparam int T_SD_NS       = 7;
   localparam int T_HZOE_NS     = 6;
   localparam int T_WC_NS       = 12;

   // least times round up to whole cycles
   localparam int RD_CYC    = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WE_CYC    = (T_PWE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TURN_CYC  = (T_HZOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W     = 4;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RD,
      ST_TURN,
      ST_WR,
      ST_WR_END
   } seq_state_e;

   typedef struct packed {
      logic                write;
      logic [ADDR_W-1:0]   addr;
      logic [DATA_W-1:0]   wdata;
      logic [LANES-1:0]    lane_n;
   } mem_req_s;

   typedef struct packed {
      logic                chip_sel_n;
      logic                write_n;
      logic                out_en_n;
      logic                lower_lane_enable_n;
      logic                upper_lane_enable_n;
      logic [ADDR_W-1:0]   word_address;
   } pin_ctl_s;

endpackage : sram_ctrl_pkg

// file: design/sram_host_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - a write needs chip select and write strobe both low.
// - device drives read data when select and output enable low, strobe high.
// - write ends on rising select or strobe; data timed to that edge.
// - strobe write with output enable low lasts turn-off plus data setup.
// - address must be valid no later than chip select falling.
module sram_host_ctrl
   import sram_ctrl_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic                        req_valid_i,
   input  wire sram_ctrl_pkg::mem_req_s     req_i,
   output logic                             req_ready_o,
   output logic                             rd_valid_o,
   output logic [DW-1:0]                    rd_data_o,
   output logic                             wr_done_o,
   output sram_ctrl_pkg::pin_ctl_s          pins_o,
   input  wire logic [DW-1:0]               shared_data_bus_i,
   output logic [DW-1:0]                    shared_data_bus_o,
   output logic [DW-1:0]                    shared_data_bus_oe_o
);
   import sram_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      seq_state_e        state;
      pin_ctl_s          pins;
      logic [DW-1:0]     dout;
      logic [DW-1:0]     oe;
      logic [DW-1:0]     rdata;
      logic [LANES-1:0]  lanes;
      logic              rd_valid;
      logic              wr_done;
      logic              ready;
   } ctl_s;

   localparam pin_ctl_s PINS_IDLE = '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1,
                                      lower_lane_enable_n: 1'b1, upper_lane_enable_n: 1'b1,
                                      word_address: '0};

   ctl_s st_r;
   ctl_s st_nxt;

   logic             tmr_load;
   logic [CNT_W-1:0] tmr_count;
   logic             tmr_done;

   cycle_timer #(.W(CNT_W)) u_timer (
      .sys_clk_i (sys_clk_i),
      .rst_b_i   (rst_b_i),
      .load_i    (tmr_load),
      .count_i   (tmr_count),
      .done_o    (tmr_done)
   );

   // per-lane mask expanded onto data bits
   function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] lane_n);
      logic [DW-1:0] m;
      m = '0;
      for (int i = 0; i < LANES; i++) begin
         m[i*8 +: 8] = {8{~lane_n[i]}};
      end
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt    = st_r;
      tmr_load  = 1'b0;
      tmr_count = '0;
      st_nxt.rd_valid = 1'b0;
      st_nxt.wr_done  = 1'b0;
      case (st_r.state)
         ST_IDLE: begin
            if (req_valid_i && st_r.ready) begin
               st_nxt.ready = 1'b0;
               st_nxt.lanes = req_i.lane_n;
               // address and select change together, so address is valid at the select edge
               st_nxt.pins.word_address        = req_i.addr[AW-1:0];
               st_nxt.pins.chip_sel_n          = 1'b0;
               st_nxt.pins.lower_lane_enable_n = req_i.lane_n[0];
               st_nxt.pins.upper_lane_enable_n = req_i.lane_n[1];
               tmr_load = 1'b1;
               if (req_i.write) begin
                  // output enable stays high on writes; turn-off need not be waited for
                  st_nxt.pins.write_n  = 1'b0;
                  st_nxt.pins.out_en_n = 1'b1;
                  st_nxt.dout          = req_i.wdata;
                  st_nxt.oe            = lane_mask(req_i.lane_n);
                  tmr_count            = CNT_W'(WE_CYC);
                  st_nxt.state         = ST_WR;
               end else begin
                  st_nxt.pins.write_n  = 1'b1;
                  st_nxt.pins.out_en_n = 1'b0;
                  st_nxt.oe            = '0;
                  tmr_count            = CNT_W'(RD_CYC);
                  st_nxt.state         = ST_RD;
               end
            end
         end
         ST_RD: begin
            if (tmr_done) begin
               st_nxt.rdata    = shared_data_bus_i & lane_mask(st_r.lanes);
               st_nxt.rd_valid = 1'b1;
               st_nxt.pins     = PINS_IDLE;
               tmr_load        = 1'b1;
               tmr_count       = CNT_W'(TURN_CYC);
               st_nxt.state    = ST_TURN;
            end
         end
         ST_TURN: begin
            // device may still drive until its turn-off delay elapses
            if (tmr_done) begin
               st_nxt.ready = 1'b1;
               st_nxt.state = ST_IDLE;
            end
         end
         ST_WR: begin
            if (tmr_done) begin
               // strobe and select rise together, data still held this edge
               st_nxt.pins.write_n    = 1'b1;
               st_nxt.pins.chip_sel_n = 1'b1;
               st_nxt.state           = ST_WR_END;
            end
         end
         ST_WR_END: begin
            // data held one cycle past the ending edge for hold time
            st_nxt.oe      = '0;
            st_nxt.pins    = PINS_IDLE;
            st_nxt.wr_done = 1'b1;
            st_nxt.ready   = 1'b1;
            st_nxt.state   = ST_IDLE;
         end
         default: begin
            st_nxt       = st_r;
            st_nxt.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r       <= '0;
         st_r.state <= ST_IDLE;
         st_r.pins  <= PINS_IDLE;
         st_r.ready <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign req_ready_o          = st_r.ready;
   assign rd_valid_o           = st_r.rd_valid;
   assign rd_data_o            = st_r.rdata;
   assign wr_done_o            = st_r.wr_done;
   assign pins_o               = st_r.pins;
   assign shared_data_bus_o    = st_r.dout;
   assign shared_data_bus_oe_o = st_r.oe;

   ////////////////////////////////////////////////////////////////////////////
   a_no_bus_fight: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !st_r.pins.out_en_n |-> st_r.oe == '0)
      else $error("host drives bus while output enable low");
   a_write_needs_cs: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !st_r.pins.write_n |-> !st_r.pins.chip_sel_n)
      else $error("write strobe low without chip select");
   a_write_width: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(st_r.pins.write_n) |-> !st_r.pins.write_n [*3])
      else $error("write strobe pulse too short");
   a_data_to_end: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(st_r.pins.write_n) |-> $stable(st_r.dout) && st_r.oe == lane_mask(st_r.lanes))
      else $error("write data not held at ending edge");
   a_joint_release: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(st_r.pins.write_n) |-> $rose(st_r.pins.chip_sel_n))
      else $error("strobe and select not released together");
   a_addr_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !st_r.pins.chip_sel_n && !$rose(st_r.pins.chip_sel_n) && !$fell(st_r.pins.chip_sel_n)
      |-> $stable(st_r.pins.word_address))
      else $error("address changed while selected");
   a_lane_drive: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      !st_r.pins.write_n |-> st_r.oe == lane_mask({st_r.pins.upper_lane_enable_n,
                                                   st_r.pins.lower_lane_enable_n}))
      else $error("driven lanes differ from enabled lanes");
   a_read_shape: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $fell(st_r.pins.out_en_n) |-> st_r.pins.write_n ##0 !st_r.pins.out_en_n [*3])
      else $error("read cycle too short or strobe low");
   a_turnaround: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      $rose(st_r.pins.out_en_n) |-> (st_r.oe == '0) [*2])
      else $error("bus driven inside turn-off window");
   a_standby: assert property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      st_r.state == ST_IDLE |-> st_r.pins.chip_sel_n)
      else $error("selected while idle");

   c_read:  cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) st_r.rd_valid);
   c_write: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i) st_r.wr_done);
   c_upper: cover property (@(posedge sys_clk_i) disable iff (!rst_b_i)
      st_r.wr_done && st_r.lanes == 2'h1);
endmodule // sram_host_ctrl
